/* idsc_params.svh */
`ifndef IDSC_PARAMS_SVH
`define IDSC_PARAMS_SVH

// register offsets
`define IDSC_OFS_VENDOR_LOW 8'h01
`define IDSC_OFS_PRODUCT 8'h02
`define IDSC_OFS_REVISION 8'h03
`define IDSC_OFS_SERIAL 8'h04
`define IDSC_OFS_STRAP 8'h08

// strap capture field layout
`define IDSC_SEL_BIT 7
`define IDSC_CODE_HI 6
`define IDSC_CODE_LO 4
`define IDSC_RSVD_HI 3
`define IDSC_RSVD_LO 0

// reset values and constants
`define IDSC_BYTE_ZERO 8'h00
`define IDSC_CODE_ZERO 3'h0
`define IDSC_CODE_MAX 3'h5
`define IDSC_CODE_PIN3_BASE 3'h3
`define IDSC_CODE_LOW_FLOAT 3'h1
`define IDSC_CODE_LOW_HIGH 3'h2
`define IDSC_CODE_HIGH_FLOAT 3'h4
`define IDSC_PINS_ZERO 4'h0
`define IDSC_SETTLE_ZERO 2'h0
`define IDSC_RSVD_ZERO 4'h0
`define IDSC_LVL_LOW 2'h0
`define IDSC_LVL_FLOAT 2'h1
`define IDSC_LVL_HIGH 2'h2

// synchroniser depth, cycles to wait after reset release
`define IDSC_SETTLE_CYCLES 2'h2
`define IDSC_CNT_ONE 2'h1

`endif

/* idsc_pkg.sv */
package idsc_pkg;

  typedef enum logic [0:0] {
    IDSC_CAP_WAIT,
    IDSC_CAP_DONE
  } idsc_cap_state_t;

  typedef enum logic [1:0] {
    IDSC_TRI_LOW,
    IDSC_TRI_FLOAT,
    IDSC_TRI_HIGH,
    IDSC_TRI_BAD
  } idsc_tri_level_t;

endpackage

/* idsc_id_strap.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "idsc_params.svh"

module idsc_id_strap #(
  // arbitrary identity values
  parameter logic [7:0] VENDOR_CODE_LOW = 8'h5a,
  parameter logic [7:0] PRODUCT_CODE = 8'h7c,
  parameter logic [7:0] DIE_REVISION = 8'h0e
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic hard_soft_select_pin_i,
  input wire logic strap3_pin_i,
  input wire logic [1:0] strap2_level_i,
  input wire logic [7:0] nvm_serial_i,
  input wire logic nvm_serial_valid_i,
  output logic serial_loaded_o,
  output logic strap_captured_o
);

  // two-flop synchronisers for the pad levels
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_sync_ff;
  logic [1:0] settle_ff;
  logic [1:0] nxt_settle;
  idsc_pkg::idsc_cap_state_t cap_state_ff;
  idsc_pkg::idsc_cap_state_t nxt_cap_state;
  logic select_ff;
  logic [2:0] pair_code_ff;
  logic [7:0] serial_ff;
  logic serial_loaded_ff;
  logic [7:0] rdata_ff;
  logic captured_ff;

  wire logic [3:0] pin_raw;
  wire logic sel_sync;
  wire logic pin3_sync;
  wire logic [1:0] pin2_sync;
  wire logic [2:0] pin2_code;
  wire logic [2:0] soft_code;
  wire logic capture_now;
  wire logic serial_load;
  wire logic [7:0] strap_byte;
  wire logic hit_vendor;
  wire logic hit_product;
  wire logic hit_revision;
  wire logic hit_serial;
  wire logic hit_strap;
  wire logic hit_any;
  wire logic [7:0] read_mux;
  wire logic [7:0] nxt_rdata;

  assign pin_raw = {hard_soft_select_pin_i, strap3_pin_i, strap2_level_i};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_ff <= `IDSC_PINS_ZERO;
      pin_sync_ff <= `IDSC_PINS_ZERO;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign sel_sync = pin_sync_ff[3];
  assign pin3_sync = pin_sync_ff[2];
  assign pin2_sync = pin_sync_ff[1:0];

  // a bad comparator code is read as floating, the safe middle level
  assign pin2_code = (pin2_sync == `IDSC_LVL_LOW) ? `IDSC_CODE_ZERO :
                     (pin2_sync == `IDSC_LVL_HIGH) ? `IDSC_CODE_LOW_HIGH :
                     `IDSC_CODE_LOW_FLOAT;
  assign soft_code = pin3_sync ?
                     3'(`IDSC_CODE_PIN3_BASE + pin2_code) :
                     pin2_code;

  // straps are static around reset; wait for synchroniser to fill
  assign capture_now = (cap_state_ff == idsc_pkg::IDSC_CAP_WAIT) &&
                       (settle_ff == `IDSC_SETTLE_CYCLES);

  always_comb begin
    nxt_settle = settle_ff;
    nxt_cap_state = cap_state_ff;
    case (cap_state_ff)
      idsc_pkg::IDSC_CAP_WAIT: begin
        if (capture_now) begin
          nxt_cap_state = idsc_pkg::IDSC_CAP_DONE;
        end else begin
          nxt_settle = 2'(settle_ff + `IDSC_CNT_ONE);
        end
      end
      idsc_pkg::IDSC_CAP_DONE: begin
        nxt_cap_state = idsc_pkg::IDSC_CAP_DONE;
      end
      default: begin
        nxt_cap_state = idsc_pkg::IDSC_CAP_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_ff <= `IDSC_SETTLE_ZERO;
      cap_state_ff <= idsc_pkg::IDSC_CAP_WAIT;
      captured_ff <= 1'b0;
    end else begin
      settle_ff <= nxt_settle;
      cap_state_ff <= nxt_cap_state;
      // own flop so the output is not a decode of the state
      captured_ff <= (nxt_cap_state == idsc_pkg::IDSC_CAP_DONE);
    end
  end

  // held until the next reset; no other path writes these
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      select_ff <= 1'b0;
      pair_code_ff <= `IDSC_CODE_ZERO;
    end else if (capture_now) begin
      select_ff <= sel_sync;
      pair_code_ff <= sel_sync ? `IDSC_CODE_ZERO : soft_code;
    end
  end

  // serial only ever loaded once from nvm; bus writes never reach it
  assign serial_load = nvm_serial_valid_i && !serial_loaded_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_ff <= `IDSC_BYTE_ZERO;
      serial_loaded_ff <= 1'b0;
    end else if (serial_load) begin
      serial_ff <= nvm_serial_i;
      serial_loaded_ff <= 1'b1;
    end
  end

  assign strap_byte = {select_ff, pair_code_ff, `IDSC_RSVD_ZERO};

  assign hit_vendor = (addr_i == `IDSC_OFS_VENDOR_LOW);
  assign hit_product = (addr_i == `IDSC_OFS_PRODUCT);
  assign hit_revision = (addr_i == `IDSC_OFS_REVISION);
  assign hit_serial = (addr_i == `IDSC_OFS_SERIAL);
  assign hit_strap = (addr_i == `IDSC_OFS_STRAP);
  assign hit_any = hit_vendor || hit_product || hit_revision ||
                   hit_serial || hit_strap;

  // unmapped offsets read zero
  assign read_mux = hit_vendor ? VENDOR_CODE_LOW :
                    hit_product ? PRODUCT_CODE :
                    hit_revision ? DIE_REVISION :
                    hit_serial ? serial_ff :
                    hit_strap ? strap_byte :
                    `IDSC_BYTE_ZERO;
  // write data is accepted and dropped; the write strobe only blocks a read in the same cycle
  assign nxt_rdata = (rd_i && !wr_i) ? read_mux : `IDSC_BYTE_ZERO;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= `IDSC_BYTE_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;
  assign serial_loaded_o = serial_loaded_ff;
  assign strap_captured_o = captured_ff;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_rd(logic [7:0] ofs);
    rd_i && !wr_i && addr_i == ofs;
  endsequence

  sequence s_load;
    nvm_serial_valid_i && !serial_loaded_ff;
  endsequence

  sequence s_soft_cap(logic p3, logic [1:0] lvl);
    capture_now && !sel_sync && pin3_sync == p3 && pin2_sync == lvl;
  endsequence

  a_vendor_read: assert property (
    s_rd(`IDSC_OFS_VENDOR_LOW) |=> rdata_o == VENDOR_CODE_LOW)
    else $error("vendor byte read wrong");

  a_product_read: assert property (
    s_rd(`IDSC_OFS_PRODUCT) |=> rdata_o == PRODUCT_CODE)
    else $error("product byte read wrong");

  a_revision_read: assert property (
    s_rd(`IDSC_OFS_REVISION) |=> rdata_o == DIE_REVISION)
    else $error("revision byte read wrong");

  a_serial_load_read: assert property (
    s_load |=> serial_ff == $past(nvm_serial_i) && serial_loaded_o)
    else $error("serial byte not taken from nvm");

  a_serial_write_safe: assert property (
    wr_i && !serial_load |=> $stable(serial_ff))
    else $error("serial byte changed without nvm load");

  a_strap_capture_time: assert property (
    $rose(rst_n_i) |-> ##[2:4] strap_captured_o)
    else $error("strap capture not done after reset");

  a_strap_hold: assert property (
    strap_captured_o |=> $stable(select_ff) && $stable(pair_code_ff)
      && strap_captured_o)
    else $error("strap capture changed before reset");

  a_select_bit_read: assert property (
    s_rd(`IDSC_OFS_STRAP) |=> rdata_o[`IDSC_SEL_BIT] == $past(select_ff))
    else $error("select bit read wrong");

  a_soft_code_value: assert property (
    capture_now && !sel_sync && pin3_sync && pin2_sync == `IDSC_LVL_HIGH
      |=> pair_code_ff == `IDSC_CODE_MAX)
    else $error("strap pair code wrong");

  a_hard_code_zero: assert property (
    s_rd(`IDSC_OFS_STRAP) ##1 rdata_o[`IDSC_SEL_BIT]
      |-> rdata_o[`IDSC_CODE_HI:`IDSC_CODE_LO] == `IDSC_CODE_ZERO)
    else $error("code not zero in hard mode");

  a_code_range: assert property (
    pair_code_ff <= `IDSC_CODE_MAX)
    else $error("strap pair code out of range");

  a_reserved_zero: assert property (
    s_rd(`IDSC_OFS_STRAP)
      |=> rdata_o[`IDSC_RSVD_HI:`IDSC_RSVD_LO] == `IDSC_RSVD_ZERO)
    else $error("reserved bits not zero");

  a_read_one_cycle: assert property (
    !rd_i |=> rdata_o == `IDSC_BYTE_ZERO)
    else $error("read data outside read answer");

  a_serial_read: assert property (
    s_rd(`IDSC_OFS_SERIAL) |=> rdata_o == $past(serial_ff))
    else $error("serial byte read wrong");

  a_loaded_flag: assert property (
    s_load |=> serial_loaded_o)
    else $error("serial load not flagged");

  a_serial_zero_early: assert property (
    !serial_loaded_ff |-> serial_ff == `IDSC_BYTE_ZERO)
    else $error("serial byte set before nvm load");

  // later nvm pulses must not reload a serial already taken
  a_serial_once: assert property (
    serial_loaded_ff |=> $stable(serial_ff) && serial_loaded_ff)
    else $error("serial byte reloaded");

  a_sync_depth: assert property (
    pin_sync_ff == $past(pin_meta_ff))
    else $error("pad synchroniser depth wrong");

  a_settle_range: assert property (
    cap_state_ff == idsc_pkg::IDSC_CAP_WAIT
      |-> settle_ff <= `IDSC_SETTLE_CYCLES)
    else $error("settle counter overran");

  a_capture_timing: assert property (
    $rose(rst_n_i) |-> !strap_captured_o [*3] ##1 strap_captured_o)
    else $error("strap capture at wrong edge");

  a_capture_once: assert property (
    strap_captured_o |-> !capture_now)
    else $error("strap capture repeated");

  a_strap_zero_early: assert property (
    !strap_captured_o
      |-> !select_ff && pair_code_ff == `IDSC_CODE_ZERO)
    else $error("strap byte set before capture");

  a_select_captured: assert property (
    capture_now |=> select_ff == $past(sel_sync))
    else $error("select level not captured");

  a_code_field_read: assert property (
    s_rd(`IDSC_OFS_STRAP)
      |=> rdata_o[`IDSC_CODE_HI:`IDSC_CODE_LO] == $past(pair_code_ff))
    else $error("strap pair code read wrong");

  a_hard_capture_zero: assert property (
    capture_now && sel_sync |=> pair_code_ff == `IDSC_CODE_ZERO)
    else $error("strap pair code kept in hard mode");

  // one check per strap pair combination; both high is checked above
  a_code_low_low: assert property (
    s_soft_cap(1'b0, `IDSC_LVL_LOW)
      |=> pair_code_ff == `IDSC_CODE_ZERO)
    else $error("strap pair code wrong, pin3 low pin2 low");

  a_code_low_float: assert property (
    s_soft_cap(1'b0, `IDSC_LVL_FLOAT)
      |=> pair_code_ff == `IDSC_CODE_LOW_FLOAT)
    else $error("strap pair code wrong, pin3 low pin2 floating");

  a_code_low_high: assert property (
    s_soft_cap(1'b0, `IDSC_LVL_HIGH)
      |=> pair_code_ff == `IDSC_CODE_LOW_HIGH)
    else $error("strap pair code wrong, pin3 low pin2 high");

  a_code_high_low: assert property (
    s_soft_cap(1'b1, `IDSC_LVL_LOW)
      |=> pair_code_ff == `IDSC_CODE_PIN3_BASE)
    else $error("strap pair code wrong, pin3 high pin2 low");

  a_code_high_float: assert property (
    s_soft_cap(1'b1, `IDSC_LVL_FLOAT)
      |=> pair_code_ff == `IDSC_CODE_HIGH_FLOAT)
    else $error("strap pair code wrong, pin3 high pin2 floating");

  a_write_no_answer: assert property (
    wr_i && !rd_i |=> rdata_o == `IDSC_BYTE_ZERO)
    else $error("write produced read data");

  a_unmapped_zero: assert property (
    rd_i && !wr_i && !hit_any |=> rdata_o == `IDSC_BYTE_ZERO)
    else $error("unmapped offset not zero");

endmodule

`default_nettype wire

/* test_idsc_id_strap.sv */
`timescale 1ns/1ps
`default_nettype none

module test_idsc_id_strap;
  // arbitrary identity values, distinct from the design defaults
  localparam logic [7:0] VEN = 8'h3c;
  localparam logic [7:0] PRD = 8'h91;
  localparam logic [7:0] REV = 8'h07;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic hard_soft_select_pin_i = 1'b0;
  logic strap3_pin_i = 1'b0;
  logic [1:0] strap2_level_i = 2'h0;
  logic [7:0] nvm_serial_i = 8'h00;
  logic nvm_serial_valid_i = 1'b0;
  logic serial_loaded_o;
  logic strap_captured_o;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  idsc_id_strap #(
    .VENDOR_CODE_LOW(VEN),
    .PRODUCT_CODE(PRD),
    .DIE_REVISION(REV)
  ) i_idsc_id_strap (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .hard_soft_select_pin_i(hard_soft_select_pin_i),
    .strap3_pin_i(strap3_pin_i),
    .strap2_level_i(strap2_level_i),
    .nvm_serial_i(nvm_serial_i),
    .nvm_serial_valid_i(nvm_serial_valid_i),
    .serial_loaded_o(serial_loaded_o),
    .strap_captured_o(strap_captured_o)
  );

  always #20 clk_i = ~clk_i;

  task automatic complete_run();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ceiling well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // straps held steady from reset through capture and a bit beyond
  task automatic do_reset(input logic s, input logic p3, input logic [1:0] l);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    hard_soft_select_pin_i <= s;
    strap3_pin_i <= p3;
    strap2_level_i <= l;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1 chk({7'h00, strap_captured_o}, 8'h00);
    repeat (3) @(posedge clk_i);
    #1 chk({7'h00, strap_captured_o}, 8'h01);
  endtask

  task automatic test_ident_serial();
    do_reset(1'b0, 1'b0, 2'h0);
    chk({7'h00, serial_loaded_o}, 8'h00);
    rd(8'h04, 8'h00);
    @(posedge clk_i);
    nvm_serial_valid_i <= 1'b1;
    nvm_serial_i <= 8'ha7;
    @(posedge clk_i);
    nvm_serial_valid_i <= 1'b0;
    nvm_serial_i <= 8'h11;
    #1 chk({7'h00, serial_loaded_o}, 8'h01);
    @(posedge clk_i);
    nvm_serial_valid_i <= 1'b1;
    @(posedge clk_i);
    nvm_serial_valid_i <= 1'b0;
    // writes of all ones and all zeros must leave every byte alone
    for (int i = 0; i < 9; i++) begin
      wr(i[7:0], 8'hff);
      wr(i[7:0], 8'h00);
    end
    rd(8'h08, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h01, VEN);
    rd(8'h02, PRD);
    rd(8'h03, REV);
    rd(8'h04, 8'ha7);
    rd(8'h04, 8'ha7);
    // read data stands one cycle, then drops back to zero
    @(posedge clk_i);
    #1 chk(rdata_o, 8'h00);
  endtask

  task automatic test_straps();
    logic [2:0] code;
    logic [1:0] lv;
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 2; p++) begin
        for (int l = 0; l < 4; l++) begin
          do_reset(s[0], p[0], l[1:0]);
          lv = (l == 3) ? 2'h1 : l[1:0];
          code = s[0] ? 3'h0 : 3'(p * 3) + {1'b0, lv};
          // move the pads after capture; the byte must not follow
          @(posedge clk_i);
          hard_soft_select_pin_i <= ~s[0];
          strap3_pin_i <= ~p[0];
          strap2_level_i <= 2'h2 - lv;
          rd(8'h08, {s[0], code, 4'h0});
          rd(8'h08, {s[0], code, 4'h0});
        end
      end
    end
    rd(8'h04, 8'h00);
  endtask

  initial begin
    test_ident_serial();
    test_straps();
    complete_run();
  end
endmodule

`default_nettype wire
